// ===== rtl/ispm_pkg.sv
// Constants, register map and types of the idle and stop power manager
package ispm_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Register indices and byte addresses
  // ****************************************
  localparam logic [7:0] PWR_CTRL_IDX = 8'h87;
  localparam logic [7:0] REG_CTRL_IDX = 8'h88;
  localparam logic [7:0] STATUS_IDX = 8'h89;
  localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = {2'h0, PWR_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] REG_CTRL_ADDR = {2'h0, REG_CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int GPF_LSB = 2;
  localparam int GPF_W = 6;
  localparam int SHUTDOWN_BIT = 0;
  localparam int ST_REGOFF_BIT = 2;
  localparam logic [GPF_W-1:0] GPF_RESET = 6'h00;
  localparam logic REG_SHUTDOWN_RESET = 1'b0;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 40;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] RESET_HOLD_CYC = CNT_W'((RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_STOP, MODE_RESET} ispm_mode_type;

  typedef enum logic [1:0] {SEL_NONE, SEL_PWR, SEL_REG, SEL_STATUS} ispm_sel_type;

  typedef struct packed {
    logic ext_pin;
    logic watchdog_timeout;
    logic missing_clk_timeout;
    logic other_internal;
  } ispm_rst_src_type;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic int_osc_en;
    logic regulator_en;
  } ispm_power_ctl_type;

  // Register select from a byte address
  function automatic ispm_sel_type ispm_decode(input logic [ADDR_W-1:0] addr);
    if (addr == PWR_CTRL_ADDR)
      ispm_decode = SEL_PWR;
    else if (addr == REG_CTRL_ADDR)
      ispm_decode = SEL_REG;
    else if (addr == STATUS_ADDR)
      ispm_decode = SEL_STATUS;
    else
      ispm_decode = SEL_NONE;
  endfunction : ispm_decode

endpackage : ispm_pkg

// ===== rtl/ispm_reset_seq.sv
// Reset source gating and reset hold counter
module ispm_reset_seq
  import ispm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Reset sources and their enables
  input wire ispm_pkg::ispm_rst_src_type rst_src,
  input wire logic watchdog_enable,
  input wire logic missing_clk_enable,
  input wire logic regulator_off,
  // Reset sequence in progress
  output logic sys_rst_active
);

  // ****************************************
  // Source gating and hold counter
  // ****************************************
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic active_reg;
  logic internal_src;
  logic take;

  always_comb
  begin
    internal_src = (rst_src.watchdog_timeout & watchdog_enable)
                 | (rst_src.missing_clk_timeout & missing_clk_enable)
                 | rst_src.other_internal;
    take = rst_src.ext_pin | (internal_src & ~regulator_off);
    if (take)
      cnt_next = RESET_HOLD_CYC;
    else if (cnt_reg != CNT_ZERO)
      cnt_next = cnt_reg - CNT_ONE;
    else
      cnt_next = CNT_ZERO;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= CNT_ZERO;
      active_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      active_reg <= (cnt_next != CNT_ZERO);
    end
  end

  assign sys_rst_active = active_reg;

endmodule : ispm_reset_seq

// ===== rtl/ispm_power_manager.sv
// Idle and stop power manager with AXI4-Lite register access
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
module ispm_power_manager
  import ispm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ispm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ispm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ispm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ispm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Wake and reset sources
  input wire logic irq_pending,
  input wire ispm_pkg::ispm_rst_src_type rst_src,
  input wire logic watchdog_enable,
  input wire logic missing_clk_enable,
  // Power and clock controls
  output ispm_pkg::ispm_power_ctl_type power_ctl,
  // Core control
  output logic sys_reset,
  output logic irq_resume,
  output logic exec_start,
  output logic [15:0] exec_addr
);

  // ****************************************
  // State
  // ****************************************
  ispm_mode_type mode_reg, mode_next;
  logic [1:0] req_reg, req_next;
  logic [GPF_W-1:0] gpf_reg, gpf_next;
  logic shutdown_reg, shutdown_next;
  logic reg_off_reg, reg_off_next;
  ispm_power_ctl_type power_reg, power_next;
  logic resume_reg, resume_next;
  logic start_reg, start_next;
  logic aw_got_reg, aw_got_next;
  logic w_got_reg, w_got_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  ispm_sel_type rsel_reg, rsel_next;
  logic sys_rst_active;
  logic wr_do;
  logic b_done;
  ispm_sel_type wsel;
  ispm_sel_type asel;

  // ****************************************
  // Reset sequencer
  // ****************************************
  ispm_reset_seq u_reset_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .rst_src(rst_src),
    .watchdog_enable(watchdog_enable),
    .missing_clk_enable(missing_clk_enable),
    .regulator_off(reg_off_reg),
    .sys_rst_active(sys_rst_active)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    wsel = ispm_decode(awaddr_reg);
    asel = ispm_decode(s_axi_araddr);
    wr_do = aw_got_reg & w_got_reg;
    b_done = bvalid_reg & s_axi_bready;
    aw_got_next = aw_got_reg;
    awaddr_next = awaddr_reg;
    w_got_next = w_got_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rsel_next = rsel_reg;
    mode_next = mode_reg;
    req_next = req_reg;
    gpf_next = gpf_reg;
    shutdown_next = shutdown_reg;
    reg_off_next = reg_off_reg;
    resume_next = 1'b0;
    start_next = 1'b0;
    // Write channels taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wstrb0_next = s_axi_wstrb[0];
    end
    if (b_done)
      bvalid_next = 1'b0;
    if (wr_do)
    begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (wsel == SEL_PWR && wstrb0_reg)
      begin
        gpf_next = wdata_reg[GPF_LSB +: GPF_W];
        if (mode_reg == MODE_RUN)
          req_next = {wdata_reg[STOP_BIT], wdata_reg[IDLE_BIT]};
      end
      else if (wsel == SEL_REG && wstrb0_reg)
        shutdown_next = wdata_reg[SHUTDOWN_BIT];
    end
    // Read channel
    if (s_axi_rvalid && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rsel_next = asel;
      rdata_next = '0;
      rresp_next = RESP_OKAY;
      if (asel == SEL_PWR)
        rdata_next[GPF_LSB +: GPF_W] = gpf_reg;
      else if (asel == SEL_REG)
        rdata_next[SHUTDOWN_BIT] = shutdown_reg;
      else if (asel == SEL_STATUS)
      begin
        rdata_next[1:0] = mode_reg;
        rdata_next[ST_REGOFF_BIT] = reg_off_reg;
      end
      else
        rresp_next = RESP_SLVERR;
    end
    // Power mode sequencing
    case (mode_reg)
      MODE_RUN:
      begin
        if (b_done && req_reg != 2'h0)
        begin
          req_next = 2'h0;
          if (req_reg[1])
          begin
            mode_next = MODE_STOP;
            reg_off_next = shutdown_reg;
          end
          else
            mode_next = MODE_IDLE;
        end
      end
      MODE_IDLE:
      begin
        if (irq_pending)
        begin
          mode_next = MODE_RUN;
          resume_next = 1'b1;
        end
      end
      MODE_STOP:
        mode_next = MODE_STOP;
      default:
      begin
        mode_next = MODE_RUN;
        start_next = 1'b1;
      end
    endcase
    // System reset returns control state to defaults
    if (sys_rst_active)
    begin
      mode_next = MODE_RESET;
      req_next = 2'h0;
      gpf_next = GPF_RESET;
      shutdown_next = REG_SHUTDOWN_RESET;
      reg_off_next = 1'b0;
      resume_next = 1'b0;
      start_next = 1'b0;
    end
    // Clock and regulator controls per mode
    power_next.core_clk_en = (mode_next == MODE_RUN) || (mode_next == MODE_RESET);
    power_next.periph_clk_en = (mode_next != MODE_STOP);
    power_next.int_osc_en = (mode_next != MODE_STOP);
    power_next.regulator_en = !((mode_next == MODE_STOP) && reg_off_next);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= MODE_RUN;
      req_reg <= 2'h0;
      gpf_reg <= GPF_RESET;
      shutdown_reg <= REG_SHUTDOWN_RESET;
      reg_off_reg <= 1'b0;
      power_reg <= 4'hF;
      resume_reg <= 1'b0;
      start_reg <= 1'b0;
      aw_got_reg <= 1'b0;
      awaddr_reg <= '0;
      w_got_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
      rsel_reg <= SEL_NONE;
    end
    else
    begin
      mode_reg <= mode_next;
      req_reg <= req_next;
      gpf_reg <= gpf_next;
      shutdown_reg <= shutdown_next;
      reg_off_reg <= reg_off_next;
      power_reg <= power_next;
      resume_reg <= resume_next;
      start_reg <= start_next;
      aw_got_reg <= aw_got_next;
      awaddr_reg <= awaddr_next;
      w_got_reg <= w_got_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      rsel_reg <= rsel_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign power_ctl = power_reg;
  assign sys_reset = sys_rst_active;
  assign irq_resume = resume_reg;
  assign exec_start = start_reg;
  assign exec_addr = RESET_VECTOR;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_IDLE_ENTRY: assert property (
    (mode_reg == MODE_RUN) && b_done && (req_reg == 2'h1) && !sys_rst_active
    |=> (mode_reg == MODE_IDLE) && !power_ctl.core_clk_en)
    else $error("idle not entered after request write completed");

  AST_IDLE_HOLD: assert property (
    (mode_reg == MODE_IDLE) && !wr_do && !sys_rst_active
    |=> $stable(gpf_reg) && $stable(shutdown_reg))
    else $error("register changed during idle");

  AST_IDLE_CLOCKS: assert property (
    (mode_reg == MODE_IDLE) |-> power_ctl.periph_clk_en && power_ctl.int_osc_en && !power_ctl.core_clk_en)
    else $error("idle gated more than the core clock");

  AST_IDLE_WAKE: assert property (
    (mode_reg == MODE_IDLE) && irq_pending && !sys_rst_active
    |=> (mode_reg == MODE_RUN) && irq_resume && power_ctl.core_clk_en ##1 !irq_resume)
    else $error("interrupt did not end idle");

  AST_RESET_VECTOR: assert property (
    $fell(sys_rst_active) |=> exec_start && (exec_addr == RESET_VECTOR) && (mode_reg == MODE_RUN))
    else $error("no restart at reset vector");

  AST_WATCHDOG_IDLE: assert property (
    (mode_reg == MODE_IDLE) && rst_src.watchdog_timeout && watchdog_enable
    |=> sys_rst_active ##1 (mode_reg == MODE_RESET))
    else $error("watchdog timeout did not end idle");

  AST_STOP_GATES: assert property (
    (mode_reg == MODE_STOP) |-> !power_ctl.core_clk_en && !power_ctl.periph_clk_en && !power_ctl.int_osc_en)
    else $error("stop left a clock running");

  AST_STOP_NO_IRQ: assert property (
    (mode_reg == MODE_STOP) && irq_pending && !sys_rst_active |=> (mode_reg == MODE_STOP) && !irq_resume)
    else $error("interrupt woke stop");

  AST_MISSING_CLK_STOP: assert property (
    (mode_reg == MODE_STOP) && !reg_off_reg && rst_src.missing_clk_timeout && missing_clk_enable
    |=> sys_rst_active[*4])
    else $error("missing clock detector did not reset stop");

  AST_REG_DEFAULT: assert property (
    (mode_reg == MODE_STOP) && !reg_off_reg |-> power_ctl.regulator_en)
    else $error("regulator off in stop without shutdown");

  AST_REG_SHUTDOWN: assert property (
    (mode_reg == MODE_RUN) && b_done && req_reg[1] && shutdown_reg && !sys_rst_active
    |=> (mode_reg == MODE_STOP) && !power_ctl.regulator_en)
    else $error("regulator not shut down in stop");

  AST_REGOFF_MASK: assert property (
    (mode_reg == MODE_STOP) && reg_off_reg && !rst_src.ext_pin && !sys_rst_active
    |=> !sys_rst_active && (mode_reg == MODE_STOP))
    else $error("internal reset acted with regulator off");

  AST_READ_ZERO: assert property (
    s_axi_rvalid && (rsel_reg == SEL_PWR) |-> (s_axi_rdata[STOP_BIT] == 1'b0) && (s_axi_rdata[IDLE_BIT] == 1'b0))
    else $error("request bit read back as one");

  AST_BOTH_STOP: assert property (
    (mode_reg == MODE_RUN) && b_done && (req_reg == 2'h3) && !sys_rst_active |=> (mode_reg == MODE_STOP))
    else $error("both request bits did not select stop");

  COV_IDLE_WAKE: cover property ((mode_reg == MODE_IDLE) ##1 irq_resume);
  COV_STOP_RESET: cover property ((mode_reg == MODE_STOP) ##1 sys_rst_active);
  COV_STOP_REGOFF: cover property ((mode_reg == MODE_STOP) && !power_ctl.regulator_en);
  COV_RESTART: cover property (exec_start);

endmodule : ispm_power_manager

// ===== test/ispm_core_model.sv
// Behavioural model of core, interrupt controller and reset logic
module ispm_core_model
  import ispm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests
  input wire logic irq_req,
  input wire ispm_pkg::ispm_rst_src_type rst_req,
  // From the power manager
  input wire logic sys_reset,
  input wire logic irq_resume,
  input wire logic exec_start,
  input wire logic [15:0] exec_addr,
  // To the power manager
  output logic irq_pending,
  output ispm_pkg::ispm_rst_src_type rst_src,
  // Observations
  output logic [7:0] n_wakes,
  output logic [7:0] n_starts,
  output logic [15:0] last_addr,
  output logic [7:0] rst_len
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] run_len;

  // ****************************************
  // Core and interrupt side
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_pending <= 1'b0;
      rst_src <= '0;
      n_wakes <= 8'h00;
      n_starts <= 8'h00;
      last_addr <= 16'hFFFF;
      rst_len <= 8'h00;
      run_len <= 8'h00;
    end
    else
    begin
      rst_src <= rst_req;
      // Pending until serviced or reset
      if (irq_resume || sys_reset)
        irq_pending <= 1'b0;
      else if (irq_req)
        irq_pending <= 1'b1;
      if (irq_resume)
        n_wakes <= n_wakes + 8'h01;
      if (exec_start)
      begin
        n_starts <= n_starts + 8'h01;
        last_addr <= exec_addr;
      end
      // Length of each reset episode
      if (sys_reset)
        run_len <= run_len + 8'h01;
      else if (run_len != 8'h00)
      begin
        rst_len <= run_len;
        run_len <= 8'h00;
      end
    end
  end
endmodule : ispm_core_model

// ===== test/tb_idle_stop_power_manager.sv
// Self-checking bench of the idle and stop power manager
module tb_idle_stop_power_manager
  import ispm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp;
  logic irq_pending, irq_req, watchdog_enable, missing_clk_enable, sys_reset, irq_resume, exec_start;
  ispm_rst_src_type rst_src, rst_req;
  ispm_power_ctl_type power_ctl;
  logic [15:0] exec_addr, last_addr;
  logic [7:0] n_wakes, n_starts, rst_len;
  int n_errors, n_compared, cycles;
  localparam ispm_rst_src_type SRC_NONE = 4'h0;
  localparam ispm_rst_src_type SRC_EXT = 4'h8;
  localparam ispm_rst_src_type SRC_WD = 4'h4;
  localparam ispm_rst_src_type SRC_MCD = 4'h2;
  localparam ispm_rst_src_type SRC_OTH = 4'h1;

  typedef struct {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ispm_row_type;

  ispm_row_type rows [9] = '{
    '{PWR_CTRL_ADDR, 32'hFFFFFFFC, 4'hF, RESP_OKAY, 32'h000000FC, RESP_OKAY},
    '{PWR_CTRL_ADDR, 32'h00000054, 4'h0, RESP_OKAY, 32'h000000FC, RESP_OKAY},
    '{PWR_CTRL_ADDR, 32'h00000000, 4'hF, RESP_OKAY, 32'h00000000, RESP_OKAY},
    '{REG_CTRL_ADDR, 32'hFFFFFFFF, 4'hF, RESP_OKAY, 32'h00000001, RESP_OKAY},
    '{REG_CTRL_ADDR, 32'h00000000, 4'hF, RESP_OKAY, 32'h00000000, RESP_OKAY},
    '{STATUS_ADDR, 32'h000000FF, 4'hF, RESP_OKAY, 32'h00000000, RESP_OKAY},
    '{12'h000, 32'h00000001, 4'hF, RESP_SLVERR, 32'h00000000, RESP_SLVERR},
    '{PWR_CTRL_ADDR + 12'h001, 32'h00000002, 4'hF, RESP_SLVERR, 32'h00000000, RESP_SLVERR},
    '{12'hFFC, 32'h00000003, 4'hF, RESP_SLVERR, 32'h00000000, RESP_SLVERR}
  };

  ispm_power_manager uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_pending(irq_pending),
    .rst_src(rst_src), .watchdog_enable(watchdog_enable), .missing_clk_enable(missing_clk_enable),
    .power_ctl(power_ctl), .sys_reset(sys_reset), .irq_resume(irq_resume), .exec_start(exec_start),
    .exec_addr(exec_addr));

  ispm_core_model partner (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .rst_req(rst_req),
    .sys_reset(sys_reset), .irq_resume(irq_resume), .exec_start(exec_start), .exec_addr(exec_addr),
    .irq_pending(irq_pending), .rst_src(rst_src), .n_wakes(n_wakes), .n_starts(n_starts),
    .last_addr(last_addr), .rst_len(rst_len));

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  always #5 aclk = ~aclk;

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    logic [1:0] r;
    r = 2'h1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    check({30'h0, r}, {30'h0, e});
  endtask : wr

  task automatic axi_read(input logic [ADDR_W-1:0] a);
    rd_resp = 2'h1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    axi_read(a);
    check({30'h0, rd_resp}, {30'h0, RESP_OKAY});
    check(rd_data, e);
  endtask : rd

  task automatic chk_pc(input logic [3:0] e);
    check({28'h0, power_ctl}, {28'h0, e});
  endtask : chk_pc

  task automatic pulse(input logic irq, input ispm_rst_src_type s);
    @(posedge aclk);
    irq_req <= irq;
    rst_req <= s;
    @(posedge aclk);
    irq_req <= 1'b0;
    rst_req <= SRC_NONE;
  endtask : pulse

  task automatic wait_for(input logic [7:0] target, input logic use_wake);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if ((use_wake ? n_wakes : n_starts) === target)
        break;
    end
    check({24'h0, use_wake ? n_wakes : n_starts}, {24'h0, target});
  endtask : wait_for

  task automatic reset_seen();
    wait_for(n_starts + 8'h01, 1'b0);
    check({16'h0, last_addr}, {16'h0, RESET_VECTOR});
    check({24'h0, rst_len}, {28'h0, RESET_HOLD_CYC});
    repeat (2) @(posedge aclk);
    chk_pc(4'hF);
  endtask : reset_seen

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, irq_req, watchdog_enable, missing_clk_enable} = 8'h00;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    rst_req = SRC_NONE;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_pc(4'hF);
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata, rows[i].wstrb, rows[i].bresp);
      axi_read(rows[i].addr);
      check({30'h0, rd_resp}, {30'h0, rows[i].rresp});
      if (rows[i].rresp === RESP_OKAY)
        check(rd_data, rows[i].rdata);
    end
    // Idle entry, retention and interrupt wake
    wr(PWR_CTRL_ADDR, 32'h000000A5, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_pc(4'h7);
    rd(PWR_CTRL_ADDR, 32'h000000A4);
    rd(STATUS_ADDR, 32'h00000001);
    pulse(1'b1, SRC_NONE);
    wait_for(n_wakes + 8'h01, 1'b1);
    chk_pc(4'hF);
    rd(STATUS_ADDR, 32'h00000000);
    // Watchdog ends idle only when enabled
    wr(PWR_CTRL_ADDR, 32'h000000A5, 4'hF, RESP_OKAY);
    pulse(1'b0, SRC_WD);
    repeat (8) @(posedge aclk);
    chk_pc(4'h7);
    watchdog_enable <= 1'b1;
    pulse(1'b0, SRC_WD);
    reset_seen();
    rd(PWR_CTRL_ADDR, 32'h00000000);
    // Both bits give stop; interrupt ignored, pin resets
    wr(PWR_CTRL_ADDR, 32'h00000003, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_pc(4'h1);
    rd(STATUS_ADDR, 32'h00000002);
    rd(PWR_CTRL_ADDR, 32'h00000000);
    pulse(1'b1, SRC_NONE);
    repeat (8) @(posedge aclk);
    chk_pc(4'h1);
    pulse(1'b0, SRC_EXT);
    reset_seen();
    // Missing clock detector ends stop
    missing_clk_enable <= 1'b1;
    wr(PWR_CTRL_ADDR, 32'h00000002, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_pc(4'h1);
    pulse(1'b0, SRC_MCD);
    reset_seen();
    // Regulator shut down in stop
    wr(REG_CTRL_ADDR, 32'h00000001, 4'hF, RESP_OKAY);
    missing_clk_enable <= 1'b0;
    wr(PWR_CTRL_ADDR, 32'h00000002, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_pc(4'h0);
    rd(STATUS_ADDR, 32'h00000006);
    pulse(1'b0, SRC_WD);
    pulse(1'b0, SRC_OTH);
    missing_clk_enable <= 1'b1;
    pulse(1'b0, SRC_MCD);
    repeat (8) @(posedge aclk);
    chk_pc(4'h0);
    pulse(1'b0, SRC_EXT);
    reset_seen();
    rd(REG_CTRL_ADDR, 32'h00000000);
    // Power cycle also ends regulator-off stop
    wr(REG_CTRL_ADDR, 32'h00000001, 4'hF, RESP_OKAY);
    wr(PWR_CTRL_ADDR, 32'h00000002, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_pc(4'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_pc(4'hF);
    rd(STATUS_ADDR, 32'h00000000);
    wrap_up();
  end
endmodule : tb_idle_stop_power_manager
